// File: core/frp_pkg.sv
// Shared constants, types and the frame check for the fault routing register bank
package frp_pkg;

    // Serial frame layout
    localparam int FRAME_W = 24;
    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam logic [4:0] CNT_DONE = 5'h18;
    localparam int DATA_W = 10;
    localparam int CRC_W = 8;

    // Register addresses
    localparam logic [4:0] ADDR_ROUTING = 5'h10;
    localparam logic [4:0] ADDR_PIN_STATE = 5'h11;
    localparam logic [4:0] ADDR_ANALOG_OUTPUT_PIN_CFG = 5'h12;

    // Routing field positions inside the ten data bits
    localparam int RT_DEADTIME = 7;
    localparam int RT_REF_UV = 1;
    localparam int RT_NEG_SUPPLY = 0;
    localparam logic [9:0] ROUTE_MASK = 10'h083;
    localparam logic [9:0] ROUTE_RST = 10'h002;

    // Pin state readback positions
    localparam int POR1_BIT = 9;
    localparam int POR2_BIT = 8;
    localparam logic [1:0] POR_RST = 2'h3;

    // Analogue output configuration reset value
    localparam logic [9:0] ANALOG_OUTPUT_PIN_CFG_RST = 10'h300;

    // Field codes
    localparam logic [1:0] TS_CUR_0P25MA = 2'h0;
    localparam logic [1:0] TS_CUR_0P50MA = 2'h1;
    localparam logic [1:0] TS_CUR_0P75MA = 2'h2;
    localparam logic [1:0] TS_CUR_1P00MA = 2'h3;
    localparam logic [1:0] OFS_0P0V = 2'h0;
    localparam logic [1:0] OFS_0P5V = 2'h1;
    localparam logic [1:0] OFS_1P0V = 2'h2;
    localparam logic [1:0] OFS_1P5V = 2'h3;
    localparam logic RANGE_5V = 1'b0;
    localparam logic RANGE_1V = 1'b1;
    localparam logic [1:0] ANALOG_OUTPUT_PIN_REG_SUPPLY = 2'h0;
    localparam logic [1:0] ANALOG_OUTPUT_PIN_AUX_INPUT = 2'h1;
    localparam logic [1:0] ANALOG_OUTPUT_PIN_POS_SUPPLY = 2'h2;
    localparam logic [1:0] ANALOG_OUTPUT_PIN_NEG_SUPPLY = 2'h3;

    // Timing of the pin readback path
    localparam int CLK_NS = 100;
    localparam int PIN_LAT_NS = 1000;
    localparam int PIN_LAT_CYC = (PIN_LAT_NS / CLK_NS) < 1 ? 1 : (PIN_LAT_NS / CLK_NS);

    // Frame check polynomial and seed, values arbitrary
    localparam logic [7:0] CRC_POLY = 8'h2f;
    localparam logic [7:0] CRC_INIT = 8'hff;

    typedef struct packed {
        logic rw;
        logic [4:0] addr;
        logic [9:0] data;
        logic [7:0] crc;
    } frp_frame_t;

    typedef struct packed {
        logic [1:0] temp_sense_current;
        logic [1:0] temp_sense_offset;
        logic temp_sense_range;
        logic aux_input_range;
        logic [1:0] aux_input_offset;
        logic [1:0] analog_out_select;
    } frp_analog_output_pin_cfg_t;

    typedef struct packed {
        logic failsafe_isolation_pin;
        logic pwm_pin;
        logic alternate_pwm_pin;
        logic failsafe_state_pin;
        logic failsafe_enable_pin;
        logic secondary_irq_pin;
        logic alternate_irq_pin;
    } frp_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CHECK,
        ST_REPLY
    } frp_state_t;

    function automatic logic [7:0] frp_crc8(input logic [15:0] msg);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
        begin
            if (c[7] ^ msg[i])
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction

endpackage

// File: core/frp_sync.sv
// Two flip-flop level synchroniser, one per bit
`timescale 1ns/100ps
module frp_sync
    import frp_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule

// File: core/frp_regs.sv
// Fault routing, pin state readback and analogue output configuration registers
`timescale 1ns/100ps
module frp_regs
    import frp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic config_mode,
    input wire logic realtime_report_select,
    input wire logic monitor_quantity_select,
    input wire logic por_event,
    input wire logic self_test_done,
    input wire logic soft_reset_cmd,
    input wire logic deadtime_fault,
    input wire logic reference_undervoltage,
    input wire logic negative_supply_range_fault,
    input wire logic self_test_failure,
    input wire logic logic_supply_range_fault,
    input wire frp_pins_t pin_levels,
    input wire logic gate_emitter_high,
    input wire logic collector_emitter_high,
    output logic secondary_irq_pin,
    output logic alternate_irq_pin,
    output frp_analog_output_pin_cfg_t analog_output_pin_cfg
);

    // ---------------- Link side, clocked by the serial clock ----------------

    logic frame_rst_n;
    logic [4:0] rx_cnt_ff;
    logic [FRAME_W-2:0] rx_sh_ff;
    logic [FRAME_W-1:0] frame_ff;
    logic frame_tgl_ff;
    logic [4:0] tx_cnt_ff;
    logic miso_ff;
    logic [FRAME_W-1:0] reply_ff;
    logic [4:0] tx_idx;

    // Bit counters restart with every frame select
    assign frame_rst_n = arst_n & ~spi_cs_n;
    assign tx_idx = LAST_BIT - tx_cnt_ff;

    // Receive on the falling edge, MSB first
    always_ff @(negedge spi_sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            rx_cnt_ff <= '0;
            rx_sh_ff <= '0;
        end
        else
        begin
            rx_sh_ff <= {rx_sh_ff[FRAME_W-3:0], spi_mosi};
            if (rx_cnt_ff != CNT_DONE)
                rx_cnt_ff <= rx_cnt_ff + 5'h01;
        end
    end

    always_ff @(negedge spi_sclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frame_ff <= '0;
            frame_tgl_ff <= 1'b0;
        end
        else if (rx_cnt_ff == LAST_BIT)
        begin
            frame_ff <= {rx_sh_ff, spi_mosi};
            frame_tgl_ff <= ~frame_tgl_ff;
        end
    end

    // Transmit on the rising edge; the reply word is loaded between frames
    always_ff @(posedge spi_sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            tx_cnt_ff <= '0;
            miso_ff <= 1'b0;
        end
        else if (tx_cnt_ff != CNT_DONE)
        begin
            miso_ff <= reply_ff[tx_idx];
            tx_cnt_ff <= tx_cnt_ff + 5'h01;
        end
    end

    assign spi_miso = miso_ff;

    // ---------------- Core side, clocked by clk ----------------

    logic [1:0] link_q;
    logic tgl_q;
    logic cs_n_q;
    logic [8:0] pin_q;
    frp_pins_t pins_q;
    logic vge_q;
    logic vce_q;

    frp_sync #(
        .W(2)
    ) u_link_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({frame_tgl_ff, spi_cs_n}),
        .q(link_q)
    );

    // two sync stages plus one register stay well inside the deadline
    frp_sync #(
        .W(9)
    ) u_pin_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({pin_levels, gate_emitter_high, collector_emitter_high}),
        .q(pin_q)
    );

    assign tgl_q = link_q[1];
    assign cs_n_q = link_q[0];
    assign pins_q = frp_pins_t'(pin_q[8:2]);
    assign vge_q = pin_q[1];
    assign vce_q = pin_q[0];

    frp_state_t state_ff;
    frp_state_t nxt_state;
    logic tgl_seen_ff;
    frp_frame_t word_ff;
    logic miso_oe_ff;
    logic [9:0] route_ff;
    logic [9:0] nxt_route;
    logic [1:0] por_ff;
    logic [1:0] nxt_por;
    frp_pins_t pins_ff;
    logic mon_sel_ff;
    logic nxt_mon_sel;
    logic mon_bit_ff;
    logic nxt_mon_bit;
    frp_analog_output_pin_cfg_t analog_output_pin_ff;
    frp_analog_output_pin_cfg_t nxt_analog_output_pin;
    logic sec_irq_ff;
    logic alt_irq_ff;

    logic new_frame;
    logic crc_ok;
    logic wr_ok;
    logic wr_route;
    logic wr_pin;
    logic wr_analog_output_pin;
    logic [1:0] por_set;
    logic [1:0] por_clr;
    logic [9:0] rd_data;
    logic [15:0] reply_head;
    logic alt_fault_mode;
    logic dt_to_alt;
    logic uv_to_alt;
    logic neg_to_alt;
    logic nxt_sec_irq;
    logic nxt_alt_irq;

    assign new_frame = tgl_q ^ tgl_seen_ff;

    // check bits cover rw, address and data
    assign crc_ok = (frp_crc8({word_ff.rw, word_ff.addr, word_ff.data}) == word_ff.crc);
    assign wr_ok = (state_ff == ST_CHECK) & crc_ok & word_ff.rw;

    assign wr_route = wr_ok & (word_ff.addr == ADDR_ROUTING) & config_mode;
    assign wr_pin = wr_ok & (word_ff.addr == ADDR_PIN_STATE);
    // analogue configuration is never write locked
    assign wr_analog_output_pin = wr_ok & (word_ff.addr == ADDR_ANALOG_OUTPUT_PIN_CFG);

    // only three routing bits are stored
    assign nxt_route = wr_route ? (word_ff.data & ROUTE_MASK) : route_ff;

    assign por_set = {2{por_event | self_test_done}};
    assign por_clr = {2{soft_reset_cmd}} | (wr_pin ? word_ff.data[POR1_BIT:POR2_BIT] : 2'h0);
    assign nxt_por = por_set | (por_ff & ~por_clr);

    // selection follows the mode register only in configuration mode
    assign nxt_mon_sel = config_mode ? monitor_quantity_select : mon_sel_ff;
    // device on reads as one for either quantity
    assign nxt_mon_bit = mon_sel_ff ? ~vce_q : vge_q;

    // fields map straight onto the data bits
    assign nxt_analog_output_pin = wr_analog_output_pin ? frp_analog_output_pin_cfg_t'(word_ff.data) : analog_output_pin_ff;

    // pin bits come from the pads, monitor bit from its own path
    assign rd_data = (word_ff.addr == ADDR_ROUTING) ? route_ff :
                     (word_ff.addr == ADDR_PIN_STATE) ? {por_ff, pins_ff, mon_bit_ff} :
                     (word_ff.addr == ADDR_ANALOG_OUTPUT_PIN_CFG) ? analog_output_pin_ff : '0;
    assign reply_head = {1'b0, word_ff.addr, rd_data};

    // alternate pin only serves faults when configured for it
    assign alt_fault_mode = realtime_report_select;
    // routing bit one selects the alternate pin
    assign dt_to_alt = route_ff[RT_DEADTIME] & alt_fault_mode;
    assign uv_to_alt = route_ff[RT_REF_UV] & alt_fault_mode;
    assign neg_to_alt = route_ff[RT_NEG_SUPPLY] & alt_fault_mode;

    // self test and logic supply faults always use the secondary pin
    assign nxt_sec_irq = self_test_failure | logic_supply_range_fault |
                         (deadtime_fault & ~dt_to_alt) |
                         (reference_undervoltage & ~uv_to_alt) |
                         (negative_supply_range_fault & ~neg_to_alt);
    assign nxt_alt_irq = (deadtime_fault & dt_to_alt) |
                         (reference_undervoltage & uv_to_alt) |
                         (negative_supply_range_fault & neg_to_alt);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (new_frame)
                    nxt_state = ST_CHECK;
            end
            ST_CHECK:
            begin
                nxt_state = ST_REPLY;
            end
            ST_REPLY:
            begin
                nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= ST_IDLE;
            tgl_seen_ff <= 1'b0;
            word_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            if ((state_ff == ST_IDLE) && new_frame)
            begin
                word_ff <= frp_frame_t'(frame_ff);
                tgl_seen_ff <= tgl_q;
            end
        end
    end

    // Reply for the next frame; a bad check leaves the old reply standing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reply_ff <= '0;
        else if ((state_ff == ST_REPLY) && crc_ok)
            reply_ff <= {reply_head, frp_crc8(reply_head)};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            route_ff <= ROUTE_RST;
            por_ff <= POR_RST;
            analog_output_pin_ff <= frp_analog_output_pin_cfg_t'(ANALOG_OUTPUT_PIN_CFG_RST);
            mon_sel_ff <= 1'b0;
        end
        else
        begin
            route_ff <= nxt_route;
            por_ff <= nxt_por;
            analog_output_pin_ff <= nxt_analog_output_pin;
            mon_sel_ff <= nxt_mon_sel;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pins_ff <= '0;
            mon_bit_ff <= 1'b0;
            sec_irq_ff <= 1'b0;
            alt_irq_ff <= 1'b0;
            miso_oe_ff <= 1'b0;
        end
        else
        begin
            pins_ff <= pins_q;
            mon_bit_ff <= nxt_mon_bit;
            sec_irq_ff <= nxt_sec_irq;
            alt_irq_ff <= nxt_alt_irq;
            miso_oe_ff <= ~cs_n_q;
        end
    end

    assign secondary_irq_pin = sec_irq_ff;
    assign alternate_irq_pin = alt_irq_ff;
    assign analog_output_pin_cfg = analog_output_pin_ff;
    assign spi_miso_oe = miso_oe_ff;

endmodule

// File: tb/frp_regs_checker.sv
// Port-level assertions for the fault routing register bank
`timescale 1ns/100ps
module frp_regs_checker
    import frp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic spi_cs_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic realtime_report_select,
    input wire logic deadtime_fault,
    input wire logic reference_undervoltage,
    input wire logic negative_supply_range_fault,
    input wire logic self_test_failure,
    input wire logic logic_supply_range_fault,
    input wire logic secondary_irq_pin,
    input wire logic alternate_irq_pin,
    input wire frp_analog_output_pin_cfg_t analog_output_pin_cfg
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    wire routable = deadtime_fault | reference_undervoltage | negative_supply_range_fault;
    wire fixed = self_test_failure | logic_supply_range_fault;
    sequence cs_idle;
        spi_cs_n [*4];
    endsequence
    sequence cs_busy;
        !spi_cs_n [*4];
    endsequence
    chk_fixed_route_sec: assert property (fixed |=> secondary_irq_pin)
        else $error("fixed fault not on secondary pin");
    chk_alt_needs_sel: assert property (!realtime_report_select |=> !alternate_irq_pin)
        else $error("alternate pin raised while not a fault output");
    chk_fallback_sec: assert property (
        !realtime_report_select && routable |=> secondary_irq_pin)
        else $error("routable fault lost without alternate pin");
    chk_quiet_no_irq: assert property (
        !(routable | fixed) |=> !secondary_irq_pin && !alternate_irq_pin)
        else $error("interrupt pin raised without a fault");
    chk_alt_has_cause: assert property (alternate_irq_pin |-> $past(routable))
        else $error("alternate pin raised without a routable fault");
    chk_analog_output_pin_reset_val: assert property ($rose(arst_n) |-> analog_output_pin_cfg == 10'h300)
        else $error("output config wrong after reset");
    chk_cfg_idle_only: assert property ($changed(analog_output_pin_cfg) |-> spi_cs_n)
        else $error("output config changed inside a frame");
    chk_oe_idle: assert property (cs_idle |-> !spi_miso_oe)
        else $error("miso enabled while deselected");
    chk_oe_busy: assert property (cs_busy |-> spi_miso_oe)
        else $error("miso not enabled while selected");
    chk_miso_idle: assert property (spi_cs_n |-> !spi_miso)
        else $error("miso not low while deselected");
endmodule

bind frp_regs frp_regs_checker i_frp_regs_checker (
    .clk, .arst_n, .spi_cs_n, .spi_miso, .spi_miso_oe, .realtime_report_select,
    .deadtime_fault, .reference_undervoltage, .negative_supply_range_fault,
    .self_test_failure, .logic_supply_range_fault, .secondary_irq_pin,
    .alternate_irq_pin, .analog_output_pin_cfg
);

// File: tb/frp_host.sv
// Host side model that sends serial frames and collects replies
`timescale 1ns/100ps
module frp_host
    import frp_pkg::*;
(
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    function automatic logic [7:0] frame_crc(input logic [15:0] m);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
        begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    task automatic xfer(input frp_frame_t f, output frp_frame_t r);
        cs_n = 1'b0;
        #300;
        for (int i = 23; i >= 0; i--)
        begin
            sclk = 1'b1;
            mosi = f[i];
            #7.5;
            sclk = 1'b0;
            r[i] = miso;
            #7.5;
        end
        cs_n = 1'b1;
        mosi = ~mosi;
        #1000;
    endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the fault routing register bank
`timescale 1ns/100ps
module tb_top
    import frp_pkg::*;
();
    logic clk, arst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic config_mode, realtime_report_select, monitor_quantity_select;
    logic por_event, self_test_done, soft_reset_cmd;
    logic gate_emitter_high, collector_emitter_high, secondary_irq_pin, alternate_irq_pin;
    logic [4:0] flt;
    frp_pins_t pin_levels;
    frp_analog_output_pin_cfg_t analog_output_pin_cfg;
    frp_frame_t rep;
    int mismatches, total_checks, cyc;

    frp_regs i_frp_regs (
        .clk, .arst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
        .config_mode, .realtime_report_select, .monitor_quantity_select,
        .por_event, .self_test_done, .soft_reset_cmd,
        .deadtime_fault(flt[4]), .reference_undervoltage(flt[3]),
        .negative_supply_range_fault(flt[2]), .self_test_failure(flt[1]),
        .logic_supply_range_fault(flt[0]), .pin_levels, .gate_emitter_high,
        .collector_emitter_high, .secondary_irq_pin, .alternate_irq_pin, .analog_output_pin_cfg
    );
    frp_host i_frp_host (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        step(1);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            results();
        end
    end

    // One access, then a read whose frame carries the reply back
    task automatic acc(input logic rw, input logic [4:0] a, input logic [9:0] d, input logic bad);
        frp_frame_t f;
        f = {rw, a, d, i_frp_host.frame_crc({rw, a, d}) ^ {7'h00, bad}};
        i_frp_host.xfer(f, rep);
        f = {1'b0, ADDR_PIN_STATE, 10'h000, 8'h00};
        f.crc = i_frp_host.frame_crc(f[23:8]);
        i_frp_host.xfer(f, rep);
        f = {1'b0, bad ? ADDR_PIN_STATE : a, rep.data, 8'h00};
        f.crc = i_frp_host.frame_crc(f[23:8]);
        check(rep, f);
    endtask

    task automatic t_reset();
        acc(1'b0, ADDR_ROUTING, 10'h000, 1'b0);
        check(24'(rep.data), 24'h002);
        acc(1'b0, ADDR_ANALOG_OUTPUT_PIN_CFG, 10'h000, 1'b0);
        check(24'(rep.data), 24'h300);
        check(24'(analog_output_pin_cfg), 24'h300);
        acc(1'b0, ADDR_PIN_STATE, 10'h000, 1'b0);
        check(24'(rep.data), 24'({2'b11, pin_levels, gate_emitter_high}));
    endtask

    task automatic t_route();
        acc(1'b1, ADDR_ROUTING, 10'h3ff, 1'b0);
        check(24'(rep.data), 24'h002);
        step(1);
        config_mode = 1'b1;
        acc(1'b1, ADDR_ROUTING, 10'h3ff, 1'b0);
        check(24'(rep.data), 24'h083);
        step(1);
        realtime_report_select = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            flt = 5'h10 >> i;
            step(2);
            check(24'({secondary_irq_pin, alternate_irq_pin}), i < 3 ? 24'h1 : 24'h2);
        end
        realtime_report_select = 1'b0;
        flt = 5'h1c;
        step(2);
        check(24'({secondary_irq_pin, alternate_irq_pin}), 24'h2);
        acc(1'b1, ADDR_ROUTING, 10'h000, 1'b0);
        step(1);
        realtime_report_select = 1'b1;
        step(2);
        check(24'({secondary_irq_pin, alternate_irq_pin}), 24'h2);
        flt = 5'h00;
        config_mode = 1'b0;
    endtask

    task automatic t_flags();
        acc(1'b1, ADDR_PIN_STATE, 10'h200, 1'b0);
        check(24'(rep.data[9:8]), 24'h1);
        pulse(soft_reset_cmd);
        acc(1'b0, ADDR_PIN_STATE, 10'h000, 1'b0);
        check(24'(rep.data[9:8]), 24'h0);
        pulse(por_event);
        acc(1'b0, ADDR_PIN_STATE, 10'h000, 1'b0);
        check(24'(rep.data[9:8]), 24'h3);
        acc(1'b1, ADDR_PIN_STATE, 10'h300, 1'b0);
        check(24'(rep.data[9:8]), 24'h0);
        pulse(self_test_done);
        acc(1'b0, ADDR_PIN_STATE, 10'h000, 1'b0);
        check(24'(rep.data[9:8]), 24'h3);
    endtask

    task automatic t_pins();
        step(1);
        pin_levels = 7'h2a;
        gate_emitter_high = 1'b1;
        monitor_quantity_select = 1'b1;
        acc(1'b0, ADDR_PIN_STATE, 10'h000, 1'b0);
        check(24'(rep.data), 24'h355);
        step(1);
        pin_levels = 7'h55;
        gate_emitter_high = 1'b1;
        acc(1'b0, ADDR_PIN_STATE, 10'h000, 1'b0);
        check(24'(rep.data), 24'h3ab);
        step(1);
        config_mode = 1'b1;
        step(2);
        config_mode = 1'b0;
        monitor_quantity_select = 1'b0;
        pin_levels = 7'h2a;
        gate_emitter_high = 1'b0;
        collector_emitter_high = 1'b0;
        acc(1'b0, ADDR_PIN_STATE, 10'h000, 1'b0);
        check(24'(rep.data), 24'h355);
        step(1);
        gate_emitter_high = 1'b1;
        collector_emitter_high = 1'b1;
        acc(1'b0, ADDR_PIN_STATE, 10'h000, 1'b0);
        check(24'(rep.data), 24'h354);
    endtask

    task automatic t_analog_output_pin();
        logic [9:0] v;
        for (int k = 0; k < 4; k++)
        begin
            v = {2'(k), 2'(k), 1'(k), 1'(k >> 1), 2'(k), 2'(k)};
            acc(1'b1, ADDR_ANALOG_OUTPUT_PIN_CFG, v, 1'b0);
            check(24'(rep.data), 24'(v));
            check(24'(analog_output_pin_cfg), 24'(v));
        end
        acc(1'b1, ADDR_ANALOG_OUTPUT_PIN_CFG, 10'h155, 1'b1);
        check(24'(analog_output_pin_cfg), 24'(v));
        acc(1'b0, ADDR_ANALOG_OUTPUT_PIN_CFG, 10'h0aa, 1'b0);
        check(24'(rep.data), 24'(v));
        acc(1'b0, 5'h1f, 10'h000, 1'b0);
        check(24'(rep.data), 24'h000);
    endtask

    initial
    begin
        arst_n = 1'b0;
        config_mode = 1'b0;
        realtime_report_select = 1'b0;
        monitor_quantity_select = 1'b0;
        por_event = 1'b0;
        self_test_done = 1'b0;
        soft_reset_cmd = 1'b0;
        flt = 5'h00;
        pin_levels = 7'h55;
        gate_emitter_high = 1'b1;
        collector_emitter_high = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        arst_n = 1'b1;
        step(3);
        t_reset();
        t_route();
        t_flags();
        t_pins();
        t_analog_output_pin();
        results();
    end
endmodule
